// ---- logic/rtcc_pkg.sv ----
// Purpose: Constants and carrier types of the calendar and calibration core.
// Assumes: Byte-wide register port driven by a serial-bus engine on clk.
// Notes: Counts are in oscillator ticks unless named otherwise.
package rtcc_pkg;
	localparam logic [3:0] OFF_SEC = 4'h0;
	localparam logic [3:0] OFF_HOUR = 4'h2;
	localparam logic [3:0] OFF_DAY = 4'h3;
	localparam logic [3:0] OFF_DATE = 4'h4;
	localparam logic [3:0] OFF_MON = 4'h5;
	localparam logic [3:0] OFF_YEAR = 4'h6;
	localparam logic [3:0] OFF_CTL = 4'h7;
	localparam logic [3:0] OFF_CHG = 4'h8;
	localparam logic [3:0] OFF_FLAG = 4'h9;
	localparam logic [3:0] OFF_LAST = 4'h9;
	// Writable bits of offsets 0 to 6; the rest read as zero.
	localparam logic [6:0][7:0] TK_MASK = {8'hff, 8'h1f, 8'h3f, 8'h07, 8'hff, 8'h7f, 8'hff};
	localparam int HALT_BIT = 7;
	localparam int CEB_BIT = 7;
	localparam int CB_BIT = 6;
	localparam int OUT_BIT = 7;
	localparam int FT_BIT = 6;
	localparam int SIGN_BIT = 5;
	localparam int OSF_BIT = 7;
	localparam logic [7:0] CTL_RESET = 8'h80;
	localparam logic [7:0] CHG_RESET = 8'h00;
	localparam logic [3:0] CHG_KEY = 4'ha;
	localparam logic [1:0] DS_NONE = 2'h1;
	localparam logic [1:0] DS_ONE = 2'h2;
	localparam logic [1:0] RESISTOR_SELECT_FIELD_OFF = 2'h0;
	localparam int OSC_HZ = 32768;
	localparam int TEST_HZ = 512;
	localparam int TEST_HALF = OSC_HZ / (2 * TEST_HZ);
	localparam int TEST_BIT = $clog2(TEST_HALF);
	localparam logic [6:0] LO_LAST = 7'h7f;
	localparam logic [8:0] HI_WRAP = 9'h100;
	localparam logic [5:0] CAL_LAST_MIN = 6'h3e;
	localparam logic [8:0] STEP_NORM = 9'h001;
	// A fast step adds two extra 256Hz counts, which is 256 oscillator cycles.
	localparam logic [8:0] STEP_FAST = 9'h003;
	localparam logic [8:0] STEP_SLOW = 9'h000;
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] DAY_MAX = 8'h07;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] FEB = 8'h02;
	typedef struct packed {
		logic ptr_load;
		logic [3:0] ptr_addr;
		logic wr_stb;
		logic [7:0] wr_data;
		logic rd_ack;
	} rtcc_req_t;
	typedef struct packed {
		logic enable;
		logic diode;
		logic [1:0] res_sel;
	} rtcc_chg_t;
endpackage : rtcc_pkg

// ---- logic/rtcc_core.sv ----
// Purpose: Clock, calendar, calibration, test pin and charger select of the RTC.
// Assumes: Oscillator clock much slower than clk; register port synchronous to clk.
// Notes: Open-drain test pin drives low while test_output_pin_oe is high.
`timescale 1ns/10ps
`default_nettype none
module rtcc_core #(
	parameter int unsigned STALL_CYCLES = 8192
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic osc_clk,
	input wire rtcc_pkg::rtcc_req_t req,
	output logic [7:0] rd_data,
	output logic test_output_pin_oe,
	output rtcc_pkg::rtcc_chg_t chg
);
	typedef struct packed {
		logic [2:0] sync;
		logic [15:0] stall;
		logic run;
		logic [6:0][7:0] tk;
		logic [7:0] ctl;
		logic [7:0] chg_sel;
		logic osc_stopped_flag;
		logic [3:0] ptr;
		logic [6:0] div_lo;
		logic [7:0] div_hi;
		logic [5:0] cal_min;
		logic cal_pend;
		logic [7:0] rd;
		logic pin_oe;
		rtcc_pkg::rtcc_chg_t chg;
	} rtcc_state_t;

	rtcc_state_t s_q;
	rtcc_state_t s_d;
	logic osc_tgl_q;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rtcc_bcd_inc(input logic [7:0] v, input logic [7:0] lim,
			input logic [7:0] first);
		if (v == lim) begin
			return first;
		end else if (v[3:0] == 4'h9) begin
			return {v[7:4] + 4'h1, 4'h0};
		end
		return v + 8'h01;
	endfunction : rtcc_bcd_inc

	function automatic logic [7:0] rtcc_month_end(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == rtcc_pkg::FEB) begin
			return leap ? 8'h29 : 8'h28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
			return 8'h30;
		end
		return 8'h31;
	endfunction : rtcc_month_end

	function automatic logic [3:0] rtcc_ptr_next(input logic [3:0] p);
		return (p == rtcc_pkg::OFF_LAST) ? 4'h0 : p + 4'h1;
	endfunction : rtcc_ptr_next

	// ----------------------------------------
	// Oscillator domain
	// ----------------------------------------
	// Only a toggle leaves this domain, so each rising oscillator edge crosses as one event.
	always_ff @(posedge osc_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_tgl_q <= 1'b0;
		end else begin
			osc_tgl_q <= ~osc_tgl_q;
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic tick;
		logic run;
		logic p256;
		logic sec_tick;
		logic [8:0] step;
		logic [8:0] hi_sum;
		logic [4:0] mag;
		logic c_min;
		logic c_hr;
		logic c_day;
		logic c_mon;
		logic c_yr;
		tick = 1'b0;
		run = 1'b0;
		p256 = 1'b0;
		sec_tick = 1'b0;
		step = rtcc_pkg::STEP_NORM;
		hi_sum = 9'h000;
		mag = s_q.ctl[4:0];
		c_min = 1'b0;
		c_hr = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_yr = 1'b0;
		s_d = s_q;
		s_d.sync = {s_q.sync[1:0], osc_tgl_q};
		tick = s_q.sync[2] ^ s_q.sync[1];
		if (tick) begin
			s_d.stall = 16'h0000;
		end else if (s_q.stall != 16'(STALL_CYCLES)) begin
			s_d.stall = s_q.stall + 16'h0001;
		end
		run = ~s_q.tk[rtcc_pkg::OFF_SEC][rtcc_pkg::HALT_BIT] &
			(s_q.stall != 16'(STALL_CYCLES));
		s_d.run = run;
		// The 512Hz tap sits below the corrected stage, so trimming never moves it.
		if (tick && run) begin
			s_d.div_lo = s_q.div_lo + 7'h01;
			p256 = (s_q.div_lo == rtcc_pkg::LO_LAST);
		end
		if (p256) begin
			if (s_q.cal_pend && mag != 5'h00) begin
				step = s_q.ctl[rtcc_pkg::SIGN_BIT] ? rtcc_pkg::STEP_FAST :
					rtcc_pkg::STEP_SLOW;
				s_d.cal_pend = 1'b0;
			end
			hi_sum = {1'b0, s_q.div_hi} + step;
			sec_tick = (hi_sum >= rtcc_pkg::HI_WRAP);
			s_d.div_hi = sec_tick ? 8'(hi_sum - rtcc_pkg::HI_WRAP) : hi_sum[7:0];
		end
		if (sec_tick) begin
			c_min = (s_q.tk[0][6:0] == rtcc_pkg::SEC_MAX[6:0]);
			s_d.tk[0] = {s_q.tk[0][7], 7'h00} |
				rtcc_bcd_inc({1'b0, s_q.tk[0][6:0]}, rtcc_pkg::SEC_MAX, 8'h00);
		end
		if (c_min) begin
			c_hr = (s_q.tk[1] == rtcc_pkg::SEC_MAX);
			s_d.tk[1] = rtcc_bcd_inc(s_q.tk[1], rtcc_pkg::SEC_MAX, 8'h00);
			s_d.cal_min = s_q.cal_min + 6'h01;
			s_d.cal_pend = (s_d.cal_min < {mag, 1'b0}) &&
				(s_d.cal_min < rtcc_pkg::CAL_LAST_MIN);
		end
		if (c_hr) begin
			c_day = (s_q.tk[2][5:0] == rtcc_pkg::HOUR_MAX[5:0]);
			s_d.tk[2] = {s_q.tk[2][7:6], 6'h00} |
				rtcc_bcd_inc({2'h0, s_q.tk[2][5:0]}, rtcc_pkg::HOUR_MAX, 8'h00);
		end
		if (c_day) begin
			s_d.tk[3] = rtcc_bcd_inc(s_q.tk[3], rtcc_pkg::DAY_MAX, 8'h01);
			c_mon = (s_q.tk[4] == rtcc_month_end(s_q.tk[5], s_q.tk[6]));
			s_d.tk[4] = c_mon ? 8'h01 : rtcc_bcd_inc(s_q.tk[4], 8'hff, 8'h01);
		end
		if (c_mon) begin
			c_yr = (s_q.tk[5] == rtcc_pkg::MON_MAX);
			s_d.tk[5] = rtcc_bcd_inc(s_q.tk[5], rtcc_pkg::MON_MAX, 8'h01);
		end
		if (c_yr) begin
			s_d.tk[6] = rtcc_bcd_inc(s_q.tk[6], rtcc_pkg::YEAR_MAX, 8'h00);
			if (s_q.tk[6] == rtcc_pkg::YEAR_MAX && s_q.tk[2][rtcc_pkg::CEB_BIT]) begin
				s_d.tk[2][rtcc_pkg::CB_BIT] = ~s_q.tk[2][rtcc_pkg::CB_BIT];
			end
		end
		// ----------------------------------------
		// Register port
		// ----------------------------------------
		if (req.wr_stb) begin
			if (s_q.ptr < rtcc_pkg::OFF_CTL) begin
				s_d.tk[s_q.ptr[2:0]] = req.wr_data & rtcc_pkg::TK_MASK[s_q.ptr[2:0]];
			end else if (s_q.ptr == rtcc_pkg::OFF_CTL) begin
				s_d.ctl = req.wr_data;
				s_d.div_lo = 7'h00;
				s_d.div_hi = 8'h00;
			end else if (s_q.ptr == rtcc_pkg::OFF_CHG) begin
				s_d.chg_sel = req.wr_data;
			end else if (s_q.ptr == rtcc_pkg::OFF_FLAG && !req.wr_data[rtcc_pkg::OSF_BIT]) begin
				s_d.osc_stopped_flag = 1'b0;
			end
		end
		if (s_q.run && !run) begin
			s_d.osc_stopped_flag = 1'b1;
		end
		if (req.ptr_load) begin
			s_d.ptr = req.ptr_addr;
		end else if (req.wr_stb || req.rd_ack) begin
			s_d.ptr = rtcc_ptr_next(s_q.ptr);
		end
		if (s_q.ptr < rtcc_pkg::OFF_CTL) begin
			s_d.rd = s_q.tk[s_q.ptr[2:0]];
		end else if (s_q.ptr == rtcc_pkg::OFF_CTL) begin
			s_d.rd = s_q.ctl;
		end else if (s_q.ptr == rtcc_pkg::OFF_CHG) begin
			s_d.rd = s_q.chg_sel;
		end else if (s_q.ptr == rtcc_pkg::OFF_FLAG) begin
			s_d.rd = {s_q.osc_stopped_flag, 7'h00};
		end else begin
			s_d.rd = 8'h00;
		end
		// ----------------------------------------
		// Pin and charger
		// ----------------------------------------
		if (s_q.ctl[rtcc_pkg::FT_BIT]) begin
			s_d.pin_oe = ~s_q.div_lo[rtcc_pkg::TEST_BIT];
		end else begin
			s_d.pin_oe = ~s_q.ctl[rtcc_pkg::OUT_BIT];
		end
		s_d.chg.enable = (s_q.chg_sel[7:4] == rtcc_pkg::CHG_KEY) &&
			(s_q.chg_sel[3:2] == rtcc_pkg::DS_NONE || s_q.chg_sel[3:2] == rtcc_pkg::DS_ONE) &&
			(s_q.chg_sel[1:0] != rtcc_pkg::RESISTOR_SELECT_FIELD_OFF);
		s_d.chg.diode = (s_q.chg_sel[3:2] == rtcc_pkg::DS_ONE);
		s_d.chg.res_sel = s_q.chg_sel[1:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
			s_q.ctl <= rtcc_pkg::CTL_RESET;
			s_q.chg_sel <= rtcc_pkg::CHG_RESET;
			s_q.osc_stopped_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rd;
	assign test_output_pin_oe = s_q.pin_oe;
	assign chg = s_q.chg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb_clk @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	sequence ctl_write_s;
		req.wr_stb && s_q.ptr == rtcc_pkg::OFF_CTL;
	endsequence
	sequence flag_clear_s;
		req.wr_stb && s_q.ptr == rtcc_pkg::OFF_FLAG && !req.wr_data[rtcc_pkg::OSF_BIT];
	endsequence
	sequence halt_set_s;
		req.wr_stb && s_q.ptr == rtcc_pkg::OFF_SEC && req.wr_data[rtcc_pkg::HALT_BIT]
			&& !s_q.tk[0][rtcc_pkg::HALT_BIT] && s_q.run;
	endsequence

	charger_key_a: assert property (chg.enable |-> $past(s_q.chg_sel[7:4]) == 4'ha)
		else $error("Charger enabled without the key.");
	diode_field_a: assert property (chg.enable |-> chg.diode ==
		($past(s_q.chg_sel[3:2]) == 2'h2) && $past(s_q.chg_sel[3:2]) != 2'h3)
		else $error("Diode selection wrong.");
	resistor_field_a: assert property (chg.enable |-> chg.res_sel != 2'h0)
		else $error("Charger enabled with no resistor.");
	halt_flag_a: assert property (halt_set_s |-> ##2 s_q.osc_stopped_flag)
		else $error("Stopped flag not set after halt.");
	flag_hold_a: assert property (s_q.osc_stopped_flag && !(req.wr_stb && s_q.ptr == rtcc_pkg::OFF_FLAG
		&& !req.wr_data[rtcc_pkg::OSF_BIT]) |=> s_q.osc_stopped_flag)
		else $error("Stopped flag dropped without a clear.");
	div_reset_a: assert property (ctl_write_s |=> s_q.div_lo == 7'h00 && s_q.div_hi == 8'h00)
		else $error("Divider not reset by control write.");
	halt_freeze_a: assert property (!s_q.run && !s_d.run
		&& !(req.wr_stb && s_q.ptr == rtcc_pkg::OFF_CTL)
		|=> $stable(s_q.div_lo))
		else $error("Divider moved while stopped.");
	out_level_a: assert property (!s_q.ctl[rtcc_pkg::FT_BIT] [*2]
		|-> test_output_pin_oe == !$past(s_q.ctl[rtcc_pkg::OUT_BIT]))
		else $error("Test pin does not follow output level.");
	pointer_step_a: assert property (req.rd_ack && !req.ptr_load && !req.wr_stb
		|=> s_q.ptr == rtcc_ptr_next($past(s_q.ptr)))
		else $error("Pointer did not advance.");
endmodule : rtcc_core
`default_nettype wire

// ---- testbench/rtcc_host_model.sv ----
// Purpose: Host side of the register port and the crystal that feeds the core.
// Assumes: Byte-level register port of the core, sampled on the rising edge of clk.
// Notes: Each request lasts one clk cycle; the crystal stands still while osc_run is low.
`timescale 1ns/10ps
`default_nettype none
module rtcc_host_model (
	input wire logic clk,
	input wire logic osc_run,
	input wire logic [7:0] rd_data,
	output rtcc_pkg::rtcc_req_t req,
	output logic osc_clk
);
	// The offset keeps crystal edges clear of clk edges.
	initial begin
		req = '0;
		osc_clk = 1'b0;
		#7;
		forever begin
			#24;
			if (osc_run) begin
				osc_clk = ~osc_clk;
			end
		end
	end

	task automatic put(input logic ld, input logic [3:0] a, input logic ws,
			input logic [7:0] d, input logic ack);
		@(posedge clk);
		req <= '{ptr_load: ld, ptr_addr: a, wr_stb: ws, wr_data: d, rd_ack: ack};
		@(posedge clk);
		req <= '0;
	endtask : put

	task automatic write(input logic [3:0] a, input logic [7:0] d);
		put(1'b1, a, 1'b0, 8'h00, 1'b0);
		put(1'b0, 4'h0, 1'b1, d, 1'b0);
		repeat (2) @(posedge clk);
	endtask : write

	task automatic settle(output logic [7:0] d);
		repeat (2) @(posedge clk);
		#1;
		d = rd_data;
	endtask : settle

	task automatic read(input logic [3:0] a, output logic [7:0] d);
		put(1'b1, a, 1'b0, 8'h00, 1'b0);
		settle(d);
	endtask : read

	task automatic next(output logic [7:0] d);
		put(1'b0, 4'h0, 1'b0, 8'h00, 1'b1);
		settle(d);
	endtask : next
endmodule : rtcc_host_model
`default_nettype wire

// ---- testbench/rtcc_core_tb.sv ----
// Purpose: Self-checking bench of the calendar and calibration core.
// Assumes: Host model drives the register port and the crystal.
// Notes: Stall limit is shortened to 64 clk so a stopped crystal is seen quickly.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module rtcc_core_tb;
	logic clk;
	logic reset_n;
	logic osc_run;
	wire logic osc_clk;
	rtcc_pkg::rtcc_req_t req;
	logic [7:0] rd_data;
	logic oe;
	rtcc_pkg::rtcc_chg_t chg;
	rtcc_pkg::rtcc_chg_t e;
	logic [7:0] v;
	int n;
	int fail_count;
	int compares;
	logic [7:0] cases [8] = '{8'ha5, 8'haa, 8'ha7, 8'hab, 8'ha1, 8'had, 8'ha4, 8'h55};

	rtcc_core #(.STALL_CYCLES(64)) uut (.clk(clk), .reset_n(reset_n), .osc_clk(osc_clk),
		.req(req), .rd_data(rd_data), .test_output_pin_oe(oe), .chg(chg));
	rtcc_host_model host (.clk(clk), .osc_run(osc_run), .rd_data(rd_data), .req(req),
		.osc_clk(osc_clk));

	initial begin
		clk = 1'b0;
		forever begin
			#4 clk = ~clk;
		end
	end

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up

	// A stuck pin gives up after 1000 cycles rather than hanging the run.
	task automatic wait_flip(output int k);
		logic p;
		p = oe;
		k = 0;
		while (oe === p && k < 1000) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : wait_flip

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end

	initial begin
		fail_count = 0;
		compares = 0;
		reset_n = 1'b0;
		osc_run = 1'b1;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		`CHK(oe, 1'b0)
		host.read(rtcc_pkg::OFF_CTL, v); `CHK(v, 8'h80)
		host.read(rtcc_pkg::OFF_CHG, v); `CHK(v, 8'h00)
		`CHK(chg.enable, 1'b0)
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h80)
		host.write(rtcc_pkg::OFF_FLAG, 8'h80);
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h80)
		host.write(rtcc_pkg::OFF_FLAG, 8'h00);
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h00)
		host.write(rtcc_pkg::OFF_SEC, 8'h80);
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h80)
		host.write(rtcc_pkg::OFF_FLAG, 8'h00);
		host.write(rtcc_pkg::OFF_SEC, 8'h00);
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h00)
		osc_run = 1'b0;
		repeat (100) @(posedge clk);
		host.read(rtcc_pkg::OFF_FLAG, v); `CHK(v, 8'h80)
		osc_run = 1'b1;
		host.write(rtcc_pkg::OFF_FLAG, 8'h00);
		// Static output level, then the square wave from a freshly cleared divider.
		host.write(rtcc_pkg::OFF_CTL, 8'h00);
		#1;
		`CHK(oe, 1'b1)
		host.write(rtcc_pkg::OFF_CTL, 8'h80);
		#1;
		`CHK(oe, 1'b0)
		host.write(rtcc_pkg::OFF_CTL, 8'h40);
		repeat (2) @(posedge clk);
		#1;
		wait_flip(n); `CHK((n >= 180 && n <= 205), 1'b1)
		wait_flip(n); `CHK((n >= 189 && n <= 195), 1'b1)
		host.write(rtcc_pkg::OFF_CTL, 8'h7f);
		repeat (2) @(posedge clk);
		wait_flip(n);
		wait_flip(n); `CHK((n >= 189 && n <= 195), 1'b1)
		host.write(rtcc_pkg::OFF_SEC, 8'h80);
		repeat (4) @(posedge clk);
		wait_flip(n); `CHK(n, 1000)
		host.write(rtcc_pkg::OFF_SEC, 8'h00);
		foreach (cases[i]) begin
			v = cases[i];
			e = '0;
			e.enable = v[7:4] == 4'ha && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && v[1:0] != 2'h0;
			e.diode = e.enable && v[3:2] == 2'h2;
			e.res_sel = e.enable ? v[1:0] : 2'h0;
			host.write(rtcc_pkg::OFF_CHG, v);
			if (e.enable) begin
				`CHK(chg, e)
			end else begin
				`CHK(chg.enable, 1'b0)
			end
			host.read(rtcc_pkg::OFF_CHG, v); `CHK(v, cases[i])
		end
		host.write(rtcc_pkg::OFF_DATE, 8'h15);
		host.put(1'b0, 4'h0, 1'b1, 8'h06, 1'b0);
		host.put(1'b0, 4'h0, 1'b1, 8'h24, 1'b0);
		host.read(rtcc_pkg::OFF_DATE, v); `CHK(v, 8'h15)
		host.next(v); `CHK(v, 8'h06)
		host.next(v); `CHK(v, 8'h24)
		host.read(rtcc_pkg::OFF_LAST, v);
		host.next(v); `CHK(v, 8'h00)
		host.read(4'ha, v); `CHK(v, 8'h00)
		wrap_up();
	end
endmodule : rtcc_core_tb
`default_nettype wire
